/* dcd_decoder.sv */
// Debug command decoder: judges each command byte from the debug link; CMD_RESERVED and codes above CMD_LAST get no verdict.
// Assumes bytes arrive already framed, one-cycle strobes on clk.
`timescale 1ns/1ps
module dcd_decoder
  import dcd_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Command bytes from the debug link deframer
  input  wire logic         cmd_valid,
  input  wire dcd_cmd_t     cmd,
  // Device state
  input  wire logic         debug_halt_flag,
  input  wire logic         readout_lock_option,
  // Control register write request
  input  wire logic         ctl_wr_valid,
  input  wire logic         ctl_wr_halt,
  // Register access beat
  input  wire logic         reg_valid,
  input  wire dcd_reg_t     reg_in,
  // Results
  output dcd_verdict_t      verdict,
  output logic              ctl_halt_next,
  output logic              ctl_wr_done,
  output logic              reg_wr_en,
  output logic              reg_rd_en,
  output dcd_reg_t          reg_out
);

  logic lock_s1, lock;
  logic halt;
  logic wr_ok, rd_ok;
  logic next_accept, next_reject;
  logic [7:0] cur_cmd;
  logic       is_wr, is_rd;

  // Lock option is a static strap; resync anyway since it comes from flash
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_s1 <= 1'b0;
      lock    <= 1'b1;
    end else begin
      lock_s1 <= readout_lock_option;
      lock    <= lock_s1;
    end
  end

  assign halt = debug_halt_flag;

  function automatic logic free_cmd(input logic [7:0] c);
    free_cmd = (c == CMD_REV_RD) || (c == CMD_STAT_RD) ||
               (c == CMD_CTL_WR) || (c == CMD_CTL_RD);
  endfunction

  function automatic logic locked_cmd(input logic [7:0] c);
    locked_cmd = (c == CMD_PC_WR)   || (c == CMD_PC_RD)   ||
                 (c == CMD_PMEM_WR) || (c == CMD_PMEM_RD) ||
                 (c == CMD_DMEM_WR) || (c == CMD_DMEM_RD) ||
                 (c == CMD_STEP)    || (c == CMD_STUFF);
  endfunction

  always_comb begin
    next_accept = 1'b0;
    next_reject = 1'b0;
    if (cmd_valid) begin
      if (cmd.code > CMD_LAST || cmd.code == CMD_RESERVED) begin
        next_accept = 1'b0;
        next_reject = 1'b0;
      end else if (!halt && !free_cmd(cmd.code)) begin
        next_reject = 1'b1;
      end else if (lock && locked_cmd(cmd.code)) begin
        next_reject = 1'b1;
      end else begin
        next_accept = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      verdict <= '0;
    end else begin
      verdict.accept <= next_accept;
      verdict.reject <= next_reject;
      if (next_accept || next_reject)
        verdict.code <= cmd.code;
    end
  end

  // Last accepted command, cleared by a rejected one; steers following payload beats
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      cur_cmd <= CMD_RESERVED;
    else if (next_accept)
      cur_cmd <= cmd.code;
    else if (next_reject)
      cur_cmd <= CMD_RESERVED;
  end

  // Control write: halt may be set freely, cleared only when unlocked
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_wr_done   <= 1'b0;
      ctl_halt_next <= 1'b0;
    end else begin
      ctl_wr_done <= ctl_wr_valid && (cur_cmd == CMD_CTL_WR);
      if (ctl_wr_valid && cur_cmd == CMD_CTL_WR)
        ctl_halt_next <= ctl_wr_halt || (lock && halt);
    end
  end

  dcd_reg_guard u_guard (
    .reg_in (reg_in),
    .lock   (lock),
    .wr_ok  (wr_ok),
    .rd_ok  (rd_ok)
  );

  assign is_wr = reg_valid && (cur_cmd == CMD_REG_WR);
  assign is_rd = reg_valid && (cur_cmd == CMD_REG_RD);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_wr_en <= 1'b0;
      reg_rd_en <= 1'b0;
      reg_out   <= '0;
    end else begin
      reg_wr_en <= is_wr && wr_ok;
      reg_rd_en <= is_rd && rd_ok;
      if (reg_valid)
        reg_out <= reg_in;
    end
  end

  property p_unknown_ignored;
    @(posedge clk) disable iff (rst)
      cmd_valid && (cmd.code > CMD_LAST || cmd.code == CMD_RESERVED)
      |=> !verdict.accept && !verdict.reject;
  endproperty
  a_unknown_ignored: assert property (p_unknown_ignored)
    else $error("reserved code produced a verdict");

  property p_run_subset;
    @(posedge clk) disable iff (rst)
      cmd_valid && !halt && cmd.code <= CMD_LAST &&
      cmd.code != CMD_RESERVED && !free_cmd(cmd.code)
      |=> verdict.reject && !verdict.accept;
  endproperty
  a_run_subset: assert property (p_run_subset)
    else $error("command accepted outside debug halt");

  property p_lock_reject;
    @(posedge clk) disable iff (rst)
      cmd_valid && lock && locked_cmd(cmd.code) |=> verdict.reject;
  endproperty
  a_lock_reject: assert property (p_lock_reject)
    else $error("locked command not rejected");

  property p_accept_code;
    @(posedge clk) disable iff (rst)
      cmd_valid && halt && !lock && cmd.code <= CMD_LAST &&
      cmd.code != CMD_RESERVED
      |=> verdict.accept && verdict.code == $past(cmd.code);
  endproperty
  a_accept_code: assert property (p_accept_code)
    else $error("valid command not accepted");

  property p_halt_kept;
    @(posedge clk) disable iff (rst)
      ctl_wr_valid && cur_cmd == CMD_CTL_WR && lock && halt
      |=> ctl_halt_next && ctl_wr_done;
  endproperty
  a_halt_kept: assert property (p_halt_kept)
    else $error("halt cleared while locked");

  property p_wr_range;
    @(posedge clk) disable iff (rst)
      is_wr && lock && reg_in.addr < PERIPH_LO |=> !reg_wr_en;
  endproperty
  a_wr_range: assert property (p_wr_range)
    else $error("locked write outside peripheral range");

  property p_flash_erase;
    @(posedge clk) disable iff (rst)
      is_wr && lock && reg_in.addr == FLASH_CTL_ADDR
      |=> reg_wr_en == ($past(reg_in.data) == MASS_ERASE_CODE);
  endproperty
  a_flash_erase: assert property (p_flash_erase)
    else $error("flash control write filter wrong");

  property p_rd_range;
    @(posedge clk) disable iff (rst)
      is_rd |=> reg_rd_en == (!$past(lock) ||
                              $past(reg_in.addr) >= PERIPH_LO);
  endproperty
  a_rd_range: assert property (p_rd_range)
    else $error("register read filter wrong");

  // Locked writes inside the peripheral range, other than flash control, must still go through
  property p_wr_inside;
    @(posedge clk) disable iff (rst)
      is_wr && lock && reg_in.addr >= PERIPH_LO &&
      reg_in.addr != FLASH_CTL_ADDR |=> reg_wr_en;
  endproperty
  a_wr_inside: assert property (p_wr_inside)
    else $error("locked peripheral write suppressed");

  // Without the lock the requested halt value is stored as given
  property p_ctl_free;
    @(posedge clk) disable iff (rst)
      ctl_wr_valid && cur_cmd == CMD_CTL_WR && !lock
      |=> ctl_wr_done && ctl_halt_next == $past(ctl_wr_halt);
  endproperty
  a_ctl_free: assert property (p_ctl_free)
    else $error("unlocked control write not applied");

  property p_unknown_state;
    @(posedge clk) disable iff (rst)
      cmd_valid && (cmd.code > CMD_LAST || cmd.code == CMD_RESERVED)
      |=> $stable(cur_cmd) && $stable(verdict.code);
  endproperty
  a_unknown_state: assert property (p_unknown_state)
    else $error("reserved code changed decoder state");

endmodule // dcd_decoder

/* dcd_pkg.sv */
// Package for the debug command decoder: command codes, address ranges,
// and the request/verdict carriers.
// Assumes a single system clock domain.
package dcd_pkg;

  localparam logic [7:0] CMD_REV_RD    = 8'h00;
  localparam logic [7:0] CMD_CNT_WR    = 8'h01;
  localparam logic [7:0] CMD_STAT_RD   = 8'h02;
  localparam logic [7:0] CMD_CNT_RD    = 8'h03;
  localparam logic [7:0] CMD_CTL_WR    = 8'h04;
  localparam logic [7:0] CMD_CTL_RD    = 8'h05;
  localparam logic [7:0] CMD_PC_WR     = 8'h06;
  localparam logic [7:0] CMD_PC_RD     = 8'h07;
  localparam logic [7:0] CMD_REG_WR    = 8'h08;
  localparam logic [7:0] CMD_REG_RD    = 8'h09;
  localparam logic [7:0] CMD_PMEM_WR   = 8'h0a;
  localparam logic [7:0] CMD_PMEM_RD   = 8'h0b;
  localparam logic [7:0] CMD_DMEM_WR   = 8'h0c;
  localparam logic [7:0] CMD_DMEM_RD   = 8'h0d;
  localparam logic [7:0] CMD_CRC_RD    = 8'h0e;
  localparam logic [7:0] CMD_RESERVED  = 8'h0f;
  localparam logic [7:0] CMD_STEP      = 8'h10;
  localparam logic [7:0] CMD_STUFF     = 8'h11;
  localparam logic [7:0] CMD_LAST      = 8'h11;

  // Peripheral control range, 12-bit register addresses
  localparam logic [11:0] PERIPH_LO    = 12'hf00;
  localparam logic [11:0] PERIPH_HI    = 12'hfff;
  // Flash control register address and mass erase code (parameters of
  // the core outside; plain defaults)
  localparam logic [11:0] FLASH_CTL_ADDR = 12'hff8;
  localparam logic [7:0]  MASS_ERASE_CODE = 8'h95;

  // One command byte from the link
  typedef struct packed {
    logic [7:0] code;
  } dcd_cmd_t;

  // One register-access beat of a register command
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  data;
  } dcd_reg_t;

  // Verdict on a command byte
  typedef struct packed {
    logic       accept;
    logic       reject;
    logic [7:0] code;
  } dcd_verdict_t;

endpackage

/* dcd_reg_guard.sv */
// Register-access filter used while the readout lock is set.
// Purely combinational; the caller registers the results.
`timescale 1ns/1ps
module dcd_reg_guard
  import dcd_pkg::*;
(
  // Access under test
  input  wire dcd_reg_t reg_in,
  input  wire logic     lock,
  // Verdicts
  output logic          wr_ok,
  output logic          rd_ok
);

  function automatic logic in_periph(input logic [11:0] a);
    in_periph = (a >= PERIPH_LO) && (a <= PERIPH_HI);
  endfunction

  always_comb begin
    // Under lock only the peripheral range, and flash control only erase
    wr_ok = !lock || (in_periph(reg_in.addr) &&
            ((reg_in.addr != FLASH_CTL_ADDR) ||
             (reg_in.data == MASS_ERASE_CODE)));
    rd_ok = !lock || in_periph(reg_in.addr);
  end

endmodule // dcd_reg_guard

/* dcd_host_model.sv */
// Behavioural debug host: sends command bytes and payload beats.
// Assumes each call starts on a clock edge and one beat at a time.
`timescale 1ns/1ps
module dcd_host_model
  import dcd_pkg::*;
(
  // Clock
  input  wire logic clk,
  // Link side
  output dcd_cmd_t  cmd,
  output logic      cmd_valid,
  output logic      ctl_wr_valid,
  output logic      ctl_wr_halt,
  output logic      reg_valid,
  output dcd_reg_t  reg_in
);
  initial begin
    cmd = '0;
    cmd_valid = 1'b0;
    ctl_wr_valid = 1'b0;
    ctl_wr_halt = 1'b0;
    reg_valid = 1'b0;
    reg_in = '0;
  end

  // Released lines show the inverse of the last beat, so a stale
  // value can never pass for a fresh one
  task automatic send_cmd(input logic [7:0] c);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd.code  <= c;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd.code  <= ~c;
  endtask

  task automatic send_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_valid <= 1'b1;
    reg_in    <= {a, d};
    @(posedge clk);
    reg_valid <= 1'b0;
    reg_in    <= ~{a, d};
  endtask

  task automatic send_ctl(input logic h);
    @(posedge clk);
    ctl_wr_valid <= 1'b1;
    ctl_wr_halt  <= h;
    @(posedge clk);
    ctl_wr_valid <= 1'b0;
    ctl_wr_halt  <= ~h;
  endtask
endmodule // dcd_host_model

/* testbench.sv */
// Self-checking bench for the debug command decoder.
// Assumes the host model drives the link; the bench sets halt and lock.
`timescale 1ns/1ps
module testbench
  import dcd_pkg::*;
;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         halt = 1'b0;
  logic         lock = 1'b0;
  dcd_cmd_t     cmd;
  logic         cmd_valid, ctl_wr_valid, ctl_wr_halt, reg_valid;
  dcd_reg_t     reg_in, reg_out;
  dcd_verdict_t verdict;
  logic         ctl_halt_next, ctl_wr_done, reg_wr_en, reg_rd_en;
  int           bad_count = 0;
  int           n_checks = 0;
  int           cycles = 0;
  logic [19:0]  seen_ar, seen_en;

  // Widen the pulse pairs once so every compare is width-clean
  assign seen_ar = 20'({verdict.accept, verdict.reject});
  assign seen_en = 20'({reg_wr_en, reg_rd_en});

  always #50 clk = ~clk;

  dcd_host_model host (.clk(clk), .cmd(cmd), .cmd_valid(cmd_valid),
    .ctl_wr_valid(ctl_wr_valid), .ctl_wr_halt(ctl_wr_halt),
    .reg_valid(reg_valid), .reg_in(reg_in));

  dcd_decoder uut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd(cmd), .debug_halt_flag(halt), .readout_lock_option(lock),
    .ctl_wr_valid(ctl_wr_valid), .ctl_wr_halt(ctl_wr_halt),
    .reg_valid(reg_valid), .reg_in(reg_in), .verdict(verdict),
    .ctl_halt_next(ctl_halt_next), .ctl_wr_done(ctl_wr_done),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_out(reg_out));

  task automatic end_of_test();
    if (bad_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic check(input string what, input logic [19:0] seen,
                       input logic [19:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Lock passes a two-flop synchroniser, so allow three edges to settle
  task automatic set_state(input logic h, input logic l);
    @(posedge clk);
    halt <= h;
    lock <= l;
    repeat (3) @(posedge clk);
  endtask

  function automatic logic [1:0] exp_verdict(logic [7:0] c, logic h,
                                             logic l);
    if (c == CMD_RESERVED || c > CMD_LAST) return 2'b00;
    if (!h && !(c inside {CMD_REV_RD, CMD_STAT_RD, CMD_CTL_WR,
                          CMD_CTL_RD})) return 2'b01;
    if (l && (c inside {CMD_PC_WR, CMD_PC_RD, CMD_PMEM_WR, CMD_PMEM_RD,
        CMD_DMEM_WR, CMD_DMEM_RD, CMD_STEP, CMD_STUFF})) return 2'b01;
    return 2'b10;
  endfunction

  task automatic t_codes(input logic h, input logic l);
    logic [1:0] e;
    set_state(h, l);
    for (int i = 0; i <= 'h12; i++) begin
      e = exp_verdict(8'(i), h, l);
      host.send_cmd(8'(i));
      @(negedge clk);
      check("verdict", seen_ar, 20'(e));
      if (e != 2'b00) check("code", 20'(verdict.code), 20'(i));
      else check("code_kept", 20'(verdict.code), 20'(i - 1));
    end
  endtask

  task automatic reg_case(input logic [7:0] c, input logic [11:0] a,
                          input logic [7:0] d, input logic [1:0] e);
    host.send_cmd(c);
    host.send_reg(a, d);
    @(negedge clk);
    check("reg_en", seen_en, 20'(e));
    if (e != 2'b00) check("reg_out", reg_out, {a, d});
  endtask

  task automatic t_reg();
    set_state(1'b1, 1'b1);
    reg_case(CMD_REG_WR, 12'hf10, 8'h5a, 2'b10);
    reg_case(CMD_REG_WR, 12'h010, 8'h5a, 2'b00);
    reg_case(CMD_REG_WR, FLASH_CTL_ADDR, MASS_ERASE_CODE, 2'b10);
    reg_case(CMD_REG_WR, FLASH_CTL_ADDR, 8'h12, 2'b00);
    reg_case(CMD_REG_RD, 12'hf00, 8'h00, 2'b01);
    reg_case(CMD_REG_RD, 12'heff, 8'h00, 2'b00);
    set_state(1'b1, 1'b0);
    reg_case(CMD_REG_WR, 12'h010, 8'h12, 2'b10);
    reg_case(CMD_REG_RD, 12'heff, 8'h00, 2'b01);
    reg_case(CMD_REG_WR, FLASH_CTL_ADDR, 8'h12, 2'b10);
    set_state(1'b0, 1'b0);
    reg_case(CMD_REG_WR, 12'hf10, 8'h12, 2'b00);
  endtask

  task automatic ctl_case(input logic h, input logic l, input logic req,
                          input logic e);
    set_state(h, l);
    host.send_cmd(CMD_CTL_WR);
    host.send_ctl(req);
    @(negedge clk);
    check("halt_next", 20'(ctl_halt_next), 20'(e));
    check("wr_done", 20'(ctl_wr_done), 20'h1);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_codes(1'b0, 1'b0);
    t_codes(1'b1, 1'b0);
    t_codes(1'b1, 1'b1);
    t_codes(1'b0, 1'b1);
    t_reg();
    ctl_case(1'b1, 1'b1, 1'b0, 1'b1);
    ctl_case(1'b1, 1'b0, 1'b0, 1'b0);
    ctl_case(1'b0, 1'b1, 1'b1, 1'b1);
    end_of_test();
  end
endmodule // testbench
